// [design/l2c_top.sv]
// Shared second-level cache controller: lookup, refill, lock, uncached path, sleep
//
// Operation
// - eight ways; legal sets depend on line size
// - 32K and 64K need 64-byte lines, no ECC
// - disabled build has no size; else 32K-8M
// - cacheable requests use arrays; uncached go direct
// - AxCACHE carries cacheable or uncacheable nature
// - uncached accelerated handled as plain uncached
// - uncached reads and writes: single or 4-beat
// - sleep acknowledge only after bus activity ends
// - acknowledge two cycles after idle sleep sample
// - few flops stay awake to see wake-up
// - no memory transactions while asleep
// - idle cache gates internal clock, not programmable
// - bypass forwards every request unchanged to memory
// - each line lockable; locked lines never evicted
// - fetch-lock miss refills, locks, makes way MRU
// - fetch-lock refill marks dirty and parity clean
// - fetch-lock hit locks, keeps LRU and dirty
`timescale 1ns/1ps
module l2c_top #(
  parameter int unsigned NCORES = 4,
  parameter int unsigned LINE_BYTES = 32,
  parameter int unsigned SETS = 512,
  parameter bit ECC_EN = 1'b0,
  parameter bit L2_EN = 1'b1
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Requests from the coherence manager
  input wire logic req_valid,
  input wire l2c_pkg::l2c_req_t req,
  output logic req_ready,
  output logic rsp_valid,
  output logic [127:0] rsp_rdata,
  // Pins: sleep, bypass, clock gate
  input wire logic [NCORES-1:0] sleep_req,
  input wire logic bypass,
  output logic cache_sleep_ack,
  output logic cache_internal_clock_en,
  // AXI memory master
  output logic awvalid,
  output l2c_pkg::l2c_axaddr_t aw,
  input wire logic awready,
  output logic wvalid,
  output logic [31:0] wdata,
  output logic wlast,
  input wire logic wready,
  input wire logic bvalid,
  output logic bready,
  output logic arvalid,
  output l2c_pkg::l2c_axaddr_t ar,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic [31:0] rdata,
  input wire logic rlast,
  output logic rready,
  // APB register slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  localparam int unsigned WAYS = l2c_pkg::WAYS;
  localparam int unsigned WAY_W = l2c_pkg::WAY_W;
  localparam int unsigned AGE_W = l2c_pkg::AGE_W;
  localparam int unsigned OFF_W = $clog2(LINE_BYTES);
  localparam int unsigned IDX_W = $clog2(SETS);
  localparam int unsigned TAG_W = 32 - OFF_W - IDX_W;
  localparam int unsigned WORD_W = OFF_W - 2;
  localparam int unsigned LINE_BITS = LINE_BYTES * 8;
  localparam logic [7:0] LINE_LEN = 8'(LINE_BYTES / 4 - 1);
  // Legal geometries; anything else leaves the cache disabled
  localparam bit POW2 = (SETS & (SETS - 1)) == 0;
  localparam bit GEOM_OK = POW2 && WAYS == 8 &&
    ((LINE_BYTES == 32 && SETS >= 512 && SETS <= 32768) ||
     (LINE_BYTES == 64 && SETS >= 512 && SETS <= 16384) ||
     // The 128K build with 64-byte lines has no room for check bits either
     (LINE_BYTES == 64 && !ECC_EN && (SETS == 64 || SETS == 128 || SETS == 256)));
  localparam bit CACHE_ON = L2_EN && GEOM_OK;
  localparam logic [15:0] SIZE_KB = CACHE_ON ? 16'(SETS * WAYS * LINE_BYTES / 1024) : 16'h0000;

  typedef struct packed {
    l2c_pkg::l2c_st_t st;
    l2c_pkg::l2c_req_t rq;
    logic byp;
    logic [WAY_W-1:0] way;
    logic [7:0] beat;
    logic [1:0] slp_cnt;
    logic [3:0] gate_cnt;
    logic ack;
    logic gate_en;
    logic req_ready;
    logic rsp_valid;
    logic [127:0] rsp_rdata;
    logic awvalid;
    l2c_pkg::l2c_axaddr_t aw;
    logic wvalid;
    logic [31:0] wdata;
    logic wlast;
    logic bready;
    logic arvalid;
    l2c_pkg::l2c_axaddr_t ar;
    logic rready;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [LINE_BITS-1:0] fill;
    logic [SETS-1:0][WAYS-1:0][TAG_W-1:0] tag;
    logic [SETS-1:0][WAYS-1:0] valid;
    logic [SETS-1:0][WAYS-1:0] dirty;
    logic [SETS-1:0][WAYS-1:0] dpar;
    logic [SETS-1:0][WAYS-1:0] lock;
    logic [SETS-1:0][WAYS-1:0][AGE_W-1:0] age;
    logic [SETS-1:0][WAYS-1:0][LINE_BITS-1:0] data;
  } l2c_state_t;

  l2c_state_t s;
  l2c_state_t n;
  logic [NCORES:0] pins_s;
  logic all_sleep;
  logic byp_s;
  logic [IDX_W-1:0] idx;
  logic [TAG_W-1:0] tagq;
  logic [WORD_W-1:0] widx;
  logic hit;
  logic [WAY_W-1:0] hway;
  logic hit_dirty;
  logic [WAY_W-1:0] vway;
  logic vfound;
  logic apb_wr;

  // Only these few flops watch the pins during sleep
  l2c_sync #(.W(NCORES + 1)) u_sync (
    .mclk(mclk),
    .rstn(rstn),
    .d({bypass, sleep_req}),
    .q(pins_s)
  );
  assign all_sleep = &pins_s[NCORES-1:0];
  assign byp_s = pins_s[NCORES];

  assign idx = s.rq.addr[OFF_W +: IDX_W];
  assign tagq = s.rq.addr[31 -: TAG_W];
  assign widx = s.rq.addr[2 +: WORD_W];
  assign hit_dirty = s.dirty[idx][hway];
  assign apb_wr = psel && penable && s.pready && pwrite;

  l2c_victim u_victim (
    .valid(s.valid[idx]),
    .lock(s.lock[idx]),
    .age(s.age[idx]),
    .way(vway),
    .found(vfound)
  );

  function automatic logic is_unc(input logic [2:0] attr);
    is_unc = attr == l2c_pkg::ATTR_UNCACHED || attr == l2c_pkg::ATTR_UNC_ACCEL;
  endfunction

  function automatic logic [3:0] axc(input logic [2:0] attr);
    axc = is_unc(attr) ? l2c_pkg::AXC_UNCACHED : l2c_pkg::AXC_WB_ALLOC;
  endfunction

  // Make way w youngest; ways younger than its old age grow older
  function automatic logic [WAYS-1:0][AGE_W-1:0] mru(input logic [WAYS-1:0][AGE_W-1:0] a,
                                                      input logic [WAY_W-1:0] w,
                                                      input logic [AGE_W-1:0] old);
    mru = a;
    for (int i = 0; i < WAYS; i++) begin
      if (i[WAY_W-1:0] == w) begin
        mru[i] = '0;
      end else if (a[i] < old) begin
        mru[i] = AGE_W'(a[i] + 1'b1);
      end
    end
  endfunction

  always_comb begin
    n = s;
    hit = 1'b0;
    hway = '0;
    for (int w = 0; w < WAYS; w++) begin
      if (s.valid[idx][w] && s.tag[idx][w] == tagq) begin
        hit = 1'b1;
        hway = w[WAY_W-1:0];
      end
    end
    // APB: zero wait states, answer in the access cycle
    n.pready = psel && !penable;
    n.pslverr = 1'b0;
    n.prdata = '0;
    if (psel && !penable) begin
      unique case (paddr)
        l2c_pkg::REG_CTRL: n.prdata = '0;
        l2c_pkg::REG_STATUS: begin
          n.prdata[l2c_pkg::STAT_SLEEP_BIT] = s.ack;
          n.prdata[l2c_pkg::STAT_BUSY_BIT] = !(s.st inside {l2c_pkg::L2C_S_IDLE, l2c_pkg::L2C_S_SLEEP});
          n.prdata[l2c_pkg::STAT_BYPASS_BIT] = byp_s;
          n.prdata[l2c_pkg::STAT_GATED_BIT] = !s.gate_en;
        end
        l2c_pkg::REG_CONFIG: begin
          n.prdata[l2c_pkg::CFG_EN_BIT] = CACHE_ON;
          n.prdata[l2c_pkg::CFG_GEOM_BIT] = GEOM_OK;
          n.prdata[l2c_pkg::CFG_ECC_BIT] = ECC_EN;
          n.prdata[l2c_pkg::CFG_OFFW_LSB +: 4] = 4'(OFF_W);
          n.prdata[l2c_pkg::CFG_IDXW_LSB +: 5] = 5'(IDX_W);
          n.prdata[l2c_pkg::CFG_SIZE_LSB +: 16] = SIZE_KB;
        end
        default: n.pslverr = 1'b1;
      endcase
    end
    // Unlock-all first so a lock set in the same cycle wins
    if (apb_wr && paddr == l2c_pkg::REG_CTRL && pwdata[l2c_pkg::CTRL_UNLOCK_BIT]) begin
      n.lock = '0;
    end
    unique case (s.st)
      l2c_pkg::L2C_S_IDLE: begin
        if (req_valid && s.req_ready) begin
          n.rq = req;
          n.req_ready = 1'b0;
          n.slp_cnt = '0;
          n.gate_cnt = '0;
          n.beat = '0;
          n.rsp_rdata = '0;
          n.byp = byp_s || !CACHE_ON;
          if (n.byp || is_unc(req.coherency_attribute)) begin
            n.st = req.write ? l2c_pkg::L2C_S_UC_AW : l2c_pkg::L2C_S_UC_AR;
          end else begin
            n.st = l2c_pkg::L2C_S_LOOK;
          end
        end else if (req_valid) begin
          // Activity restarts clocks before anything is taken
          n.gate_en = 1'b1;
          n.gate_cnt = '0;
          n.slp_cnt = '0;
          n.req_ready = 1'b1;
        end else if (all_sleep) begin
          if (2'(s.slp_cnt + 2'h1) == l2c_pkg::SLEEP_ACK_CYC) begin
            n.ack = 1'b1;
            n.gate_en = 1'b0;
            n.req_ready = 1'b0;
            n.st = l2c_pkg::L2C_S_SLEEP;
          end else begin
            n.slp_cnt = 2'(s.slp_cnt + 2'h1);
          end
        end else begin
          n.slp_cnt = '0;
          if (s.gate_cnt == l2c_pkg::GATE_DELAY_CYC) begin
            n.gate_en = 1'b0;
            n.req_ready = 1'b0;
          end else begin
            n.gate_cnt = 4'(s.gate_cnt + 4'h1);
            n.req_ready = s.gate_en;
          end
        end
      end
      l2c_pkg::L2C_S_LOOK: begin
        n.st = l2c_pkg::L2C_S_IDLE;
        if (hit) begin
          unique case (s.rq.op)
            l2c_pkg::L2C_OP_FETCH_LOCK: n.lock[idx][hway] = 1'b1;
            l2c_pkg::L2C_OP_MAINT: begin
              n.way = hway;
              if (s.dirty[idx][hway]) begin
                n.st = l2c_pkg::L2C_S_WB_AW;
              end else begin
                n.valid[idx][hway] = 1'b0;
                n.lock[idx][hway] = 1'b0;
              end
            end
            l2c_pkg::L2C_OP_ACCESS: begin
              n.age[idx] = mru(s.age[idx], hway, s.age[idx][hway]);
              if (s.rq.write) begin
                n.data[idx][hway][32*widx +: 32] = s.rq.wdata[31:0];
                n.dirty[idx][hway] = 1'b1;
                n.dpar[idx][hway] = 1'b1;
              end else begin
                n.rsp_rdata = {96'h0, s.data[idx][hway][32*widx +: 32]};
              end
            end
            default: n.st = l2c_pkg::L2C_S_IDLE;
          endcase
        end else if (s.rq.op == l2c_pkg::L2C_OP_MAINT) begin
          n.st = l2c_pkg::L2C_S_IDLE;
        end else if (!vfound) begin
          // Every way locked: serve the request from memory instead
          n.st = s.rq.write ? l2c_pkg::L2C_S_UC_AW : l2c_pkg::L2C_S_UC_AR;
        end else begin
          n.way = vway;
          n.st = (s.valid[idx][vway] && s.dirty[idx][vway]) ? l2c_pkg::L2C_S_WB_AW : l2c_pkg::L2C_S_RF_AR;
        end
      end
      l2c_pkg::L2C_S_WB_AW, l2c_pkg::L2C_S_UC_AW: begin
        if (awready) begin
          n.beat = '0;
          n.st = (s.st == l2c_pkg::L2C_S_WB_AW) ? l2c_pkg::L2C_S_WB_W : l2c_pkg::L2C_S_UC_W;
        end
      end
      l2c_pkg::L2C_S_WB_W, l2c_pkg::L2C_S_UC_W: begin
        if (wready) begin
          n.beat = 8'(s.beat + 8'h01);
          if (s.wlast) begin
            n.st = (s.st == l2c_pkg::L2C_S_WB_W) ? l2c_pkg::L2C_S_WB_B : l2c_pkg::L2C_S_UC_B;
          end
        end
      end
      l2c_pkg::L2C_S_WB_B: begin
        if (bvalid) begin
          n.dirty[idx][s.way] = 1'b0;
          n.dpar[idx][s.way] = 1'b0;
          if (s.rq.op == l2c_pkg::L2C_OP_MAINT) begin
            n.valid[idx][s.way] = 1'b0;
            n.lock[idx][s.way] = 1'b0;
            n.st = l2c_pkg::L2C_S_IDLE;
          end else begin
            n.valid[idx][s.way] = 1'b0;
            n.st = l2c_pkg::L2C_S_RF_AR;
          end
        end
      end
      l2c_pkg::L2C_S_UC_B: begin
        if (bvalid) begin
          n.st = l2c_pkg::L2C_S_IDLE;
        end
      end
      l2c_pkg::L2C_S_RF_AR, l2c_pkg::L2C_S_UC_AR: begin
        if (arready) begin
          n.beat = '0;
          n.st = (s.st == l2c_pkg::L2C_S_RF_AR) ? l2c_pkg::L2C_S_RF_R : l2c_pkg::L2C_S_UC_R;
        end
      end
      l2c_pkg::L2C_S_RF_R: begin
        if (rvalid) begin
          n.fill[32*s.beat[WORD_W-1:0] +: 32] = rdata;
          n.beat = 8'(s.beat + 8'h01);
          if (rlast) begin
            // Line enters clean and youngest; the replay of the request then hits
            n.data[idx][s.way] = n.fill;
            n.tag[idx][s.way] = tagq;
            n.valid[idx][s.way] = 1'b1;
            n.dirty[idx][s.way] = 1'b0;
            n.dpar[idx][s.way] = 1'b0;
            n.lock[idx][s.way] = s.rq.op == l2c_pkg::L2C_OP_FETCH_LOCK;
            n.age[idx] = mru(s.age[idx], s.way, l2c_pkg::AGE_MAX);
            n.st = l2c_pkg::L2C_S_LOOK;
          end
        end
      end
      l2c_pkg::L2C_S_UC_R: begin
        if (rvalid) begin
          n.rsp_rdata[32*s.beat[1:0] +: 32] = rdata;
          n.beat = 8'(s.beat + 8'h01);
          if (rlast) begin
            n.st = l2c_pkg::L2C_S_IDLE;
          end
        end
      end
      l2c_pkg::L2C_S_SLEEP: begin
        if (!all_sleep) begin
          n.ack = 1'b0;
          n.gate_en = 1'b1;
          n.req_ready = 1'b0;
          n.slp_cnt = '0;
          n.gate_cnt = '0;
          n.st = l2c_pkg::L2C_S_IDLE;
        end
      end
    endcase
    // Bus outputs follow the next state, so each comes from a flop
    n.rsp_valid = n.st == l2c_pkg::L2C_S_IDLE && s.st != l2c_pkg::L2C_S_IDLE && s.st != l2c_pkg::L2C_S_SLEEP;
    n.awvalid = n.st inside {l2c_pkg::L2C_S_WB_AW, l2c_pkg::L2C_S_UC_AW};
    n.arvalid = n.st inside {l2c_pkg::L2C_S_RF_AR, l2c_pkg::L2C_S_UC_AR};
    n.wvalid = n.st inside {l2c_pkg::L2C_S_WB_W, l2c_pkg::L2C_S_UC_W};
    n.bready = n.st inside {l2c_pkg::L2C_S_WB_B, l2c_pkg::L2C_S_UC_B};
    n.rready = n.st inside {l2c_pkg::L2C_S_RF_R, l2c_pkg::L2C_S_UC_R};
    if (n.st inside {l2c_pkg::L2C_S_WB_AW, l2c_pkg::L2C_S_WB_W, l2c_pkg::L2C_S_WB_B}) begin
      n.aw = '{addr: {s.tag[idx][n.way], idx, {OFF_W{1'b0}}}, len: LINE_LEN, cache: l2c_pkg::AXC_WB_ALLOC};
      n.wdata = s.data[idx][n.way][32*n.beat[WORD_W-1:0] +: 32];
    end else begin
      n.aw = '{addr: n.rq.addr, len: n.rq.burst4 ? l2c_pkg::UC_LEN_BURST4 : l2c_pkg::UC_LEN_SINGLE,
               cache: axc(n.rq.coherency_attribute)};
      n.wdata = n.rq.wdata[32*n.beat[1:0] +: 32];
    end
    n.wlast = n.beat == n.aw.len;
    if (n.st inside {l2c_pkg::L2C_S_RF_AR, l2c_pkg::L2C_S_RF_R}) begin
      n.ar = '{addr: {tagq, idx, {OFF_W{1'b0}}}, len: LINE_LEN, cache: l2c_pkg::AXC_WB_ALLOC};
    end else begin
      n.ar = '{addr: n.rq.addr, len: n.rq.burst4 ? l2c_pkg::UC_LEN_BURST4 : l2c_pkg::UC_LEN_SINGLE,
               cache: axc(n.rq.coherency_attribute)};
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
      s.st <= l2c_pkg::L2C_S_IDLE;
      s.gate_en <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign req_ready = s.req_ready;
  assign rsp_valid = s.rsp_valid;
  assign rsp_rdata = s.rsp_rdata;
  assign cache_sleep_ack = s.ack;
  assign cache_internal_clock_en = s.gate_en;
  assign awvalid = s.awvalid;
  assign aw = s.aw;
  assign wvalid = s.wvalid;
  assign wdata = s.wdata;
  assign wlast = s.wlast;
  assign bready = s.bready;
  assign arvalid = s.arvalid;
  assign ar = s.ar;
  assign rready = s.rready;
  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;

  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);

  a_sleep_ack_two: assert property ($rose(s.ack) |->
    $past(all_sleep && !req_valid && s.st == l2c_pkg::L2C_S_IDLE, 1) &&
    $past(all_sleep && !req_valid && s.st == l2c_pkg::L2C_S_IDLE, 2)) else $error("sleep ack timing wrong");
  a_ack_after_idle: assert property (s.ack |-> s.st == l2c_pkg::L2C_S_SLEEP) else $error("ack while busy");
  a_sleep_no_bus: assert property (s.ack |-> !s.awvalid && !s.arvalid && !s.wvalid)
    else $error("bus traffic during sleep");
  a_wake_restart: assert property (s.st == l2c_pkg::L2C_S_SLEEP && !all_sleep |=>
    !s.ack && s.gate_en && !s.req_ready) else $error("wake-up not handled");
  a_gate_only_idle: assert property (!s.gate_en |-> s.st inside {l2c_pkg::L2C_S_IDLE, l2c_pkg::L2C_S_SLEEP})
    else $error("clock gated while busy");
  a_look_cacheable: assert property (s.st == l2c_pkg::L2C_S_LOOK |-> !s.byp && !is_unc(s.rq.coherency_attribute))
    else $error("uncached request looked up");
  a_uc_axcache: assert property (s.arvalid && s.st == l2c_pkg::L2C_S_UC_AR |->
    s.ar.cache == axc(s.rq.coherency_attribute) && s.ar.addr == s.rq.addr) else $error("read attribute wrong");
  a_uc_burst_len: assert property (s.awvalid && s.st == l2c_pkg::L2C_S_UC_AW |->
    s.aw.len == (s.rq.burst4 ? l2c_pkg::UC_LEN_BURST4 : l2c_pkg::UC_LEN_SINGLE)) else $error("uncached length wrong");
  a_fill_lock_clean: assert property (s.st == l2c_pkg::L2C_S_RF_R && rvalid && rlast &&
    s.rq.op == l2c_pkg::L2C_OP_FETCH_LOCK |=> s.lock[idx][s.way] && !s.dirty[idx][s.way] &&
    !s.dpar[idx][s.way] && s.age[idx][s.way] == '0 && s.st == l2c_pkg::L2C_S_LOOK) else $error("fill-lock wrong");
  a_victim_unlocked: assert property (s.st == l2c_pkg::L2C_S_LOOK && !hit && vfound |-> !s.lock[idx][vway])
    else $error("locked way chosen");
  a_fl_hit_keeps: assert property (s.st == l2c_pkg::L2C_S_LOOK && hit && s.rq.op == l2c_pkg::L2C_OP_FETCH_LOCK |=>
    s.lock[$past(idx)][$past(hway)] && s.dirty[$past(idx)][$past(hway)] == $past(hit_dirty) &&
    s.age[$past(idx)] == $past(s.age[idx]) &&
    s.st == l2c_pkg::L2C_S_IDLE && s.rsp_valid) else $error("fetch-lock hit wrong");

  c_sleep_entered: cover property ($rose(s.ack));
  c_fetch_lock_hit: cover property (s.st == l2c_pkg::L2C_S_LOOK && hit && s.rq.op == l2c_pkg::L2C_OP_FETCH_LOCK);
  c_uc_burst_read: cover property (s.st == l2c_pkg::L2C_S_UC_R && rvalid && rlast && s.rq.burst4);
  c_dirty_evict: cover property (s.st == l2c_pkg::L2C_S_WB_B && bvalid);
endmodule

// [pkg/l2c_pkg.sv]
// Shared constants, states and carrier types of the shared cache controller
package l2c_pkg;
  localparam int unsigned WAYS = 8;
  localparam int unsigned WAY_W = 3;
  localparam int unsigned AGE_W = 3;
  localparam logic [AGE_W-1:0] AGE_MAX = 3'h7;
  // Register map (byte addresses)
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [11:0] REG_CONFIG = 12'h008;
  localparam int unsigned CTRL_UNLOCK_BIT = 0;
  localparam int unsigned STAT_SLEEP_BIT = 0;
  localparam int unsigned STAT_BUSY_BIT = 1;
  localparam int unsigned STAT_BYPASS_BIT = 2;
  localparam int unsigned STAT_GATED_BIT = 3;
  localparam int unsigned CFG_EN_BIT = 0;
  localparam int unsigned CFG_GEOM_BIT = 1;
  localparam int unsigned CFG_ECC_BIT = 2;
  localparam int unsigned CFG_OFFW_LSB = 4;
  localparam int unsigned CFG_IDXW_LSB = 8;
  localparam int unsigned CFG_SIZE_LSB = 16;
  // Coherency attribute codes that mean uncached
  localparam logic [2:0] ATTR_UNCACHED = 3'h2;
  localparam logic [2:0] ATTR_UNC_ACCEL = 3'h7;
  // AXI cache attribute and uncached burst length values
  localparam logic [3:0] AXC_UNCACHED = 4'h0;
  localparam logic [3:0] AXC_WB_ALLOC = 4'hF;
  localparam logic [7:0] UC_LEN_SINGLE = 8'h00;
  localparam logic [7:0] UC_LEN_BURST4 = 8'h03;
  // Timing counts in manager clock cycles
  localparam logic [1:0] SLEEP_ACK_CYC = 2'h2;
  localparam logic [3:0] GATE_DELAY_CYC = 4'h8;

  typedef enum logic [1:0] {
    L2C_OP_ACCESS = 2'h0,
    L2C_OP_FETCH_LOCK = 2'h1,
    L2C_OP_MAINT = 2'h2
  } l2c_op_t;

  typedef enum logic [12:0] {
    L2C_S_IDLE = 13'h0001, L2C_S_LOOK = 13'h0002, L2C_S_WB_AW = 13'h0004,
    L2C_S_WB_W = 13'h0008, L2C_S_WB_B = 13'h0010, L2C_S_RF_AR = 13'h0020,
    L2C_S_RF_R = 13'h0040, L2C_S_UC_AW = 13'h0080, L2C_S_UC_W = 13'h0100,
    L2C_S_UC_B = 13'h0200, L2C_S_UC_AR = 13'h0400, L2C_S_UC_R = 13'h0800,
    L2C_S_SLEEP = 13'h1000
  } l2c_st_t;

  typedef struct packed {
    logic [31:0] addr;
    logic write;
    logic [2:0] coherency_attribute;
    logic burst4;
    l2c_op_t op;
    logic [127:0] wdata;
  } l2c_req_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [7:0] len;
    logic [3:0] cache;
  } l2c_axaddr_t;
endpackage

// [design/l2c_sync.sv]
// Two-flop synchroniser for pin-level inputs
`timescale 1ns/1ps
module l2c_sync #(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } l2c_sync_t;
  l2c_sync_t s;
  l2c_sync_t n;

  // First stage feeds only the second stage
  always_comb begin
    n = s;
    n.s1 = d;
    n.s2 = s.s1;
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign q = s.s2;
endmodule

// [design/l2c_victim.sv]
// Eviction way choice among the unlocked ways of one set
`timescale 1ns/1ps
module l2c_victim (
  // Set state
  input wire logic [l2c_pkg::WAYS-1:0] valid,
  input wire logic [l2c_pkg::WAYS-1:0] lock,
  input wire logic [l2c_pkg::WAYS-1:0][l2c_pkg::AGE_W-1:0] age,
  // Choice
  output logic [l2c_pkg::WAY_W-1:0] way,
  output logic found
);
  // Free ways first, else the oldest; locked ways are never offered
  always_comb begin
    logic [l2c_pkg::AGE_W-1:0] best;
    logic free;
    best = '0;
    free = 1'b0;
    way = '0;
    found = 1'b0;
    for (int i = 0; i < l2c_pkg::WAYS; i++) begin
      if (!lock[i]) begin
        if (!valid[i] && !free) begin
          free = 1'b1;
          found = 1'b1;
          way = i[l2c_pkg::WAY_W-1:0];
        end else if (valid[i] && !free && (!found || age[i] > best)) begin
          found = 1'b1;
          best = age[i];
          way = i[l2c_pkg::WAY_W-1:0];
        end
      end
    end
  end
endmodule

// [testbench/l2c_mem.sv]
// Memory side model of the AXI port: address-pattern data, prompt answers
`timescale 1ns/1ps
module l2c_mem (
  // Clock and reset
  input wire logic mclk, rstn,
  // Write channels
  input wire logic awvalid, wvalid, wlast, bready,
  output logic awready, wready, bvalid,
  // Read channels
  input wire logic arvalid, rready,
  input wire l2c_pkg::l2c_axaddr_t ar,
  output logic arready, rvalid, rlast,
  output logic [31:0] rdata
);
  logic [7:0] cnt;
  logic [31:0] a;
  assign awready = 1'b1;
  assign wready = 1'b1;
  assign rlast = rvalid && cnt == 8'h00;
  // Idle read data is inverted so a stale beat never looks right
  assign rdata = rvalid ? a : ~a;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      {arready, rvalid, bvalid, cnt, a} <= '0;
    end else begin
      arready <= arvalid && !arready && !rvalid;
      bvalid <= (wvalid && wlast) || (bvalid && !bready);
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        a <= ar.addr;
        cnt <= ar.len;
      end else if (rvalid && rready) begin
        rvalid <= cnt != 8'h00;
        cnt <= cnt - 8'h01;
        a <= a + 32'h4;
      end
    end
  end
endmodule

// [testbench/shared_l2_cache_control_bench.sv]
// Self-checking bench of the shared cache controller
`timescale 1ns/1ps
module shared_l2_cache_control_bench;
  logic mclk = 0, rstn = 0, req_valid = 0, req_ready, rsp_valid, bypass = 0, ack, cken, pslverr, e;
  logic awvalid, wvalid, wlast, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid, rlast;
  logic psel = 0, penable = 0, pwrite = 0, pready;
  logic [3:0] sleep_req = 0;
  logic [11:0] paddr = 0;
  logic [31:0] wdata, rdata, prdata, d, a, w_s, pwdata = 0;
  logic [127:0] rsp_rdata;
  l2c_pkg::l2c_req_t req = '0;
  l2c_pkg::l2c_axaddr_t aw, ar, ar_s, aw_s;
  int error_cnt = 0, n_tests = 0, n_ar = 0, n0, n_w = 0;
  initial forever #5 mclk = ~mclk;
  l2c_top #(.LINE_BYTES(64), .SETS(64)) u_dut (.mclk, .rstn, .req_valid, .req, .req_ready, .rsp_valid,
    .rsp_rdata, .sleep_req, .bypass, .cache_sleep_ack(ack), .cache_internal_clock_en(cken), .awvalid,
    .aw, .awready, .wvalid, .wdata, .wlast, .wready, .bvalid, .bready, .arvalid, .ar, .arready, .rvalid,
    .rdata, .rlast, .rready, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
  l2c_mem u_mem (.mclk, .rstn, .awvalid, .wvalid, .wlast, .bready, .awready, .wready, .bvalid,
    .arvalid, .rready, .ar, .arready, .rvalid, .rlast, .rdata);
  always @(posedge mclk) begin
    if (arvalid && arready) begin
      ar_s <= ar;
      n_ar <= n_ar + 1;
    end
    if (awvalid && awready) aw_s <= aw;
    if (wvalid && wready) begin
      w_s <= wdata;
      n_w <= n_w + 1;
    end
  end
  task automatic chk(input string nm, input logic [127:0] s, x);
    n_tests++;
    if (s !== x) begin
      error_cnt++;
      $display("ERROR %s exp %h got %h", nm, x, s);
    end
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic waitfor(ref logic s, input int lim);
    for (int i = 0; i < lim; i++) begin
      @(negedge mclk);
      if (s === 1'b1) return;
    end
    error_cnt++;
    final_report();
  endtask
  task automatic apb(input logic [11:0] ad);
    @(posedge mclk);
    psel <= 1;
    paddr <= ad;
    @(posedge mclk);
    penable <= 1;
    // Answer is taken at the very edge that samples pready high
    for (int i = 0; i < 20; i++) begin
      @(posedge mclk);
      if (pready === 1'b1) break;
      if (i == 19) begin
        error_cnt++;
        final_report();
      end
    end
    d = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic rq(input logic [31:0] ad, input logic w, input logic [2:0] at, input logic b4, input int op);
    @(posedge mclk);
    req_valid <= 1;
    req <= '{ad, w, at, b4, l2c_pkg::l2c_op_t'(op), {ad + 32'hC, ad + 32'h8, ad + 32'h4, ad}};
    waitfor(req_ready, 200);
    @(posedge mclk);
    req_valid <= 0;
    waitfor(rsp_valid, 400);
  endtask
  initial begin
    void'($urandom(32'h850B26A0));
    repeat (8) @(posedge mclk);
    rstn <= 1;
    repeat (2) @(posedge mclk);
    apb(l2c_pkg::REG_CONFIG);
    chk("config", {e, d}, {1'b0, 32'h0020_0663});
    apb(12'h0FC);
    chk("unmapped", {e, d}, {1'b1, 32'h0});
    for (int i = 0; i < 4; i++) begin
      a = $urandom & 32'hFFFF_FFF0;
      rq(a, 0, i[0] ? l2c_pkg::ATTR_UNC_ACCEL : l2c_pkg::ATTR_UNCACHED, i[1], 0);
      chk("uc ar", ar_s, {a, i[1] ? 8'h03 : 8'h00, 4'h0});
      chk("uc data", i[1] ? rsp_rdata : rsp_rdata[31:0], i[1] ? {a + 32'hC, a + 32'h8, a + 32'h4, a} : a);
    end
    rq(a, 1, l2c_pkg::ATTR_UNCACHED, 1, 0);
    chk("uc aw", aw_s, {a, 8'h03, 4'h0});
    chk("uc w", {n_w, w_s}, {32'd4, a + 32'hC});
    // Lock one way only; the other seven stay free for refills
    rq(32'h2000_0008, 0, 3'h3, 0, 1);
    // The lock itself returns no data, so read the word back; it must hit
    n0 = n_ar;
    rq(32'h2000_0008, 0, 3'h3, 0, 0);
    chk("lock fill", {n_ar, ar_s, rsp_rdata[31:0]}, {n0, 44'h2000_0000_0FF, 32'h2000_0008});
    for (int k = 1; k < 10; k++) rq(32'h2000_0000 + k * 4096, 0, 3'h3, 0, 0);
    n0 = n_ar;
    rq(32'h2000_0004, 0, 3'h3, 0, 0);
    chk("locked kept", {n_ar, rsp_rdata[31:0]}, {n0, 32'h2000_0004});
    // Only clean lines are held, so the switch needs no flush here
    @(posedge mclk);
    bypass <= 1;
    // Pin passes two sync flops before a request may see it
    repeat (3) @(posedge mclk);
    for (int j = 0; j < 2; j++) begin
      n0 = n_ar;
      rq(32'h2000_0006, 0, 3'h3, 0, j * 2);
      chk("bypass ar", {n_ar, ar_s}, {n0 + 1, 32'h2000_0006, 8'h00, 4'hF});
    end
    bypass <= 0;
    repeat (8) @(negedge mclk);
    chk("gate early", cken, 1'b1);
    @(negedge mclk);
    chk("gated", cken, 1'b0);
    @(posedge mclk);
    sleep_req <= 4'hF;
    repeat (4) @(negedge mclk);
    chk("early ack", ack, 1'b0);
    waitfor(ack, 1);
    repeat (4) @(negedge mclk);
    chk("asleep bus", {ack, arvalid, awvalid}, 3'b100);
    apb(l2c_pkg::REG_STATUS);
    chk("status", {e, d}, {1'b0, 32'h0000_0009});
    @(posedge mclk);
    sleep_req[2] <= 0;
    repeat (5) @(negedge mclk);
    chk("wake", {ack, cken}, 2'b01);
    @(posedge mclk);
    sleep_req <= 0;
    rq(32'h4000_0000, 0, l2c_pkg::ATTR_UNCACHED, 0, 0);
    chk("after wake", rsp_rdata[31:0], 32'h4000_0000);
    final_report();
  end
endmodule
